/* File: src/dpc_descriptor_perm_check.sv */
// Two-level descriptor fetch, decode and permission check for one core access at a time.
// Assumes the memory answers each fetch with one FETCH_VALID pulse, at least one cycle later.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
module dpc_descriptor_perm_check (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // Register port
    input wire logic [dpc_pkg::REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Core access request and answer
    input wire logic REQ_VALID,
    input wire dpc_pkg::dpc_req_t REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output dpc_pkg::dpc_rsp_t RSP,
    // Translation table fetch
    output logic FETCH_REQ,
    output logic [31:0] FETCH_ADDR,
    input wire logic FETCH_VALID,
    input wire logic [31:0] FETCH_DATA
);
    import dpc_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [1:0] domain_mode(input logic [31:0] dacr, input logic [3:0] idx);
        domain_mode = dacr[{idx, 1'b0} +: 2];
    endfunction

    function automatic logic perm_ok(input logic [1:0] ap, input logic s, input logic r,
                                     input logic user, input logic write);
        perm_ok = 1'b0;
        if (s && r) begin
            perm_ok = 1'b0;
        end else begin
            case (ap)
                AP_SPECIAL: begin
                    if (s) begin
                        perm_ok = !user && !write;
                    end else if (r) begin
                        perm_ok = !write;
                    end else begin
                        perm_ok = 1'b0;
                    end
                end
                AP_SUPER_RW: perm_ok = !user;
                AP_USER_RO: perm_ok = !user || !write;
                AP_ALL_RW: perm_ok = 1'b1;
                default: perm_ok = 1'b0;
            endcase
        end
    endfunction

    // Domain first, then permission only for clients; managers are never checked
    function automatic logic [3:0] access_code(input logic [1:0] dmode, input logic ok,
                                               input logic [3:0] dom_fc, input logic [3:0] perm_fc);
        access_code = FC_NONE;
        case (dmode)
            DOM_NO_ACCESS: access_code = dom_fc;
            DOM_RESERVED: access_code = dom_fc;
            DOM_CLIENT: access_code = ok ? FC_NONE : perm_fc;
            DOM_MANAGER: access_code = FC_NONE;
            default: access_code = dom_fc;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dpc_state_t state_r, state_nxt;
    logic [31:TTB_LSB] ttb_r;
    logic [31:0] dacr_r;
    logic [31:0] ctrl_r;
    logic [31:0] rdata_r;
    dpc_req_t req_r;
    logic [31:0] l1_desc_r;
    logic fetch_req_r;
    logic [31:0] fetch_addr_r;
    logic rsp_valid_r;
    dpc_rsp_t rsp_r, rsp_nxt;
    logic last_fault_r;
    logic [3:0] last_code_r;
    logic [3:0] last_dom_r;
    logic [31:0] last_paddr_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire st_idle = (state_r == ST_IDLE);
    wire st_l1 = (state_r == ST_L1);
    wire st_l2 = (state_r == ST_L2);
    wire start = st_idle && REQ_VALID;
    wire sys_prot = ctrl_r[CTRL_SYS_PROT];
    wire rom_prot = ctrl_r[CTRL_ROM_PROT];
    wire cache_en = ctrl_r[CTRL_CACHE_EN];
    wire wbuf_en = ctrl_r[CTRL_WBUF_EN];

    wire [31:0] l1_addr = {ttb_r, REQ.vaddr[31:20], 2'h0};
    wire [1:0] l1_type = FETCH_DATA[1:0];
    wire l1_done = st_l1 && FETCH_VALID;
    wire l1_bad = (l1_type == L1_INVALID) || (l1_type == L1_RESERVED);
    wire l1_table = (l1_type == L1_PAGE_TABLE);
    wire [31:0] l2_addr = {FETCH_DATA[31:10], req_r.vaddr[19:12], 2'h0};

    wire [3:0] l1_dom = FETCH_DATA[DESC_DOM_LSB +: 4];
    wire [3:0] l2_dom = l1_desc_r[DESC_DOM_LSB +: 4];
    wire [1:0] sect_dmode = domain_mode(dacr_r, l1_dom);
    wire [1:0] page_dmode = domain_mode(dacr_r, l2_dom);
    wire sect_ok = perm_ok(FETCH_DATA[SECT_AP_LSB +: 2], sys_prot, rom_prot, req_r.user, req_r.write);
    wire [3:0] sect_code = access_code(sect_dmode, sect_ok, FC_SECT_DOMAIN, FC_SECT_PERM);

    wire [1:0] l2_type = FETCH_DATA[1:0];
    wire l2_large = (l2_type == L2_LARGE);
    wire l2_bad = (l2_type == L2_INVALID) || (l2_type == L2_RESERVED);
    // Large pages pick the sub-page from higher virtual bits than small pages
    wire [1:0] sub_sel = l2_large ? req_r.vaddr[15:14] : req_r.vaddr[11:10];
    wire [1:0] sub_ap = FETCH_DATA[PTE_AP_LSB + {sub_sel, 1'b0} +: 2];
    wire page_ok = perm_ok(sub_ap, sys_prot, rom_prot, req_r.user, req_r.write);
    wire [3:0] page_code = access_code(page_dmode, page_ok, FC_PAGE_DOMAIN, FC_PAGE_PERM);

    wire [31:0] sect_pa = {FETCH_DATA[31:20], req_r.vaddr[19:0]};
    wire [31:0] page_pa = l2_large ? {FETCH_DATA[31:16], req_r.vaddr[15:0]} :
                                     {FETCH_DATA[31:12], req_r.vaddr[11:0]};

    wire [3:0] fin_code = st_l1 ? (l1_bad ? FC_SECT_TRANS : sect_code) :
                                  (l2_bad ? FC_PAGE_TRANS : page_code);
    wire fin_fault = (fin_code != FC_NONE);
    wire finish = FETCH_VALID && (st_l2 || (st_l1 && !l1_table));
    wire [31:0] fin_pa = st_l1 ? sect_pa : page_pa;

    // Attributes are only meaningful once the access is allowed
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.fault = fin_fault;
        rsp_nxt.fault_code = fin_code;
        rsp_nxt.domain = st_l1 ? l1_dom : l2_dom;
        if (!fin_fault) begin
            rsp_nxt.paddr = fin_pa;
            rsp_nxt.cacheable = FETCH_DATA[DESC_C_BIT] && cache_en;
            rsp_nxt.bufferable = FETCH_DATA[DESC_B_BIT] && wbuf_en && req_r.write;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (REQ_VALID) begin
                    state_nxt = ST_L1;
                end
            end
            ST_L1: begin
                if (FETCH_VALID) begin
                    state_nxt = (!l1_bad && l1_table) ? ST_L2 : ST_IDLE;
                end
            end
            ST_L2: begin
                if (FETCH_VALID) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    wire go_l2 = l1_done && !l1_bad && l1_table;
    wire fetch_nxt = start || go_l2;
    wire [31:0] fetch_addr_nxt = start ? l1_addr : (go_l2 ? l2_addr : fetch_addr_r);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    wire wr_ttb = REG_WR && (REG_ADDR == REG_TABLE_BASE);
    wire wr_dacr = REG_WR && (REG_ADDR == REG_DOMAIN_CTRL);
    wire wr_ctrl = REG_WR && (REG_ADDR == REG_CONTROL);
    wire [31:0] status_word = {16'h0000, 4'h0, last_dom_r, last_code_r, 2'h0, last_fault_r, !st_idle};
    wire [31:0] rd_word = (REG_ADDR == REG_TABLE_BASE) ? {ttb_r, 14'h0000} :
                          (REG_ADDR == REG_DOMAIN_CTRL) ? dacr_r :
                          (REG_ADDR == REG_CONTROL) ? ctrl_r :
                          (REG_ADDR == REG_STATUS) ? status_word :
                          (REG_ADDR == REG_LAST_PADDR) ? last_paddr_r : 32'h0000_0000;

    // Config changes mid-walk take effect immediately; software should idle first
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ttb_r <= RST_TABLE_BASE[31:TTB_LSB];
            dacr_r <= RST_DOMAIN_CTRL;
            ctrl_r <= RST_CONTROL;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (wr_ttb) begin
                ttb_r <= REG_WDATA[31:TTB_LSB];
            end
            if (wr_dacr) begin
                dacr_r <= REG_WDATA;
            end
            if (wr_ctrl) begin
                ctrl_r <= REG_WDATA & 32'h0000_030C;
            end
            rdata_r <= REG_RD ? rd_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Walk sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_r <= ST_IDLE;
            req_r <= '0;
            l1_desc_r <= 32'h0000_0000;
            fetch_req_r <= 1'b0;
            fetch_addr_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            fetch_req_r <= fetch_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            if (start) begin
                req_r <= REQ;
            end
            if (l1_done) begin
                l1_desc_r <= FETCH_DATA;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            last_fault_r <= 1'b0;
            last_code_r <= FC_NONE;
            last_dom_r <= 4'h0;
            last_paddr_r <= 32'h0000_0000;
        end else begin
            rsp_valid_r <= finish;
            if (finish) begin
                rsp_r <= rsp_nxt;
                last_fault_r <= rsp_nxt.fault;
                last_code_r <= rsp_nxt.fault_code;
                last_dom_r <= rsp_nxt.domain;
                last_paddr_r <= rsp_nxt.paddr;
            end
        end
    end

    assign REG_RDATA = rdata_r;
    assign REQ_READY = st_idle;
    assign RSP_VALID = rsp_valid_r;
    assign RSP = rsp_r;
    assign FETCH_REQ = fetch_req_r;
    assign FETCH_ADDR = fetch_addr_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    a_l1_fetch_addr: assert property (start |=> FETCH_REQ && FETCH_ADDR == {ttb_r, req_r.vaddr[31:20], 2'h0})
        else $error("level one fetch address wrong");
    a_l1_trans_fault: assert property (l1_done && l1_bad |=> RSP_VALID && RSP.fault_code == FC_SECT_TRANS)
        else $error("invalid level one descriptor did not fault");
    a_cache_attr: assert property (l1_done && !l1_table && FETCH_DATA[DESC_C_BIT] && cache_en && !fin_fault
                                   |=> RSP.cacheable)
        else $error("cacheable section not marked cacheable");
    a_buffer_read: assert property (RSP_VALID && !req_r.write |-> !RSP.bufferable)
        else $error("read marked bufferable");
    a_domain_index: assert property (l1_done && !l1_bad |=> l1_desc_r[8:5] == $past(FETCH_DATA[8:5]))
        else $error("domain index not captured");
    a_manager_noperm: assert property (finish && (st_l1 ? sect_dmode : page_dmode) == DOM_MANAGER
                                       && !(st_l1 ? l1_bad : l2_bad) |=> !RSP.fault)
        else $error("manager domain faulted");
    a_both_prot_fault: assert property (finish && sys_prot && rom_prot && !(st_l1 ? l1_bad : l2_bad)
                                        && (st_l1 ? sect_dmode : page_dmode) == DOM_CLIENT
                                        |=> RSP.fault && RSP.fault_code[3:2] == 2'h3)
        else $error("reserved protection setting allowed access");
    a_no_pa_on_fault: assert property (RSP_VALID && RSP.fault |-> RSP.paddr == 32'h0000_0000)
        else $error("physical address given on a fault");
    a_l2_follows: assert property (go_l2 |=> FETCH_REQ && FETCH_ADDR[31:10] == l1_desc_r[31:10] && st_l2)
        else $error("level two fetch not issued");
    a_l2_reserved: assert property (st_l2 && FETCH_VALID && l2_type == L2_RESERVED
                                    |=> RSP_VALID && RSP.fault_code == FC_PAGE_TRANS)
        else $error("reserved entry did not fault");
    a_small_page_pa: assert property (RSP_VALID && !RSP.fault && $past(st_l2) && $past(l2_type) == L2_SMALL
                                      |-> RSP.paddr[11:0] == req_r.vaddr[11:0])
        else $error("small page offset wrong");
    a_user_write_f10: assert property (st_l2 && FETCH_VALID && !l2_bad && page_dmode == DOM_CLIENT
                                       && sub_ap == AP_USER_RO && req_r.user && req_r.write
                                       |=> RSP.fault_code == FC_PAGE_PERM)
        else $error("user write to read-only sub-page allowed");

    // ------------------------------------------------------------
    // Permission table checks
    // ------------------------------------------------------------
    // Section answers that reach the permission stage in a client domain
    wire sect_client = l1_done && !l1_table && !l1_bad && sect_dmode == DOM_CLIENT;
    wire [1:0] sect_ap = FETCH_DATA[SECT_AP_LSB +: 2];

    a_sect_pa: assert property (l1_done && !l1_table && !fin_fault
                                |=> RSP.paddr == {$past(FETCH_DATA[31:20]), req_r.vaddr[19:0]})
        else $error("section physical address wrong");

    a_ap00_none: assert property (sect_client && sect_ap == AP_SPECIAL && !sys_prot && !rom_prot
                                  |=> RSP.fault_code == FC_SECT_PERM)
        else $error("field 00 without protection allowed access");

    a_ap00_sys: assert property (sect_client && sect_ap == AP_SPECIAL && sys_prot && !rom_prot
                                 && (req_r.user || req_r.write) |=> RSP.fault_code == FC_SECT_PERM)
        else $error("system protection allowed more than supervisor read");

    a_ap00_rom_read: assert property (sect_client && sect_ap == AP_SPECIAL && !sys_prot && rom_prot
                                      && !req_r.write |=> !RSP.fault)
        else $error("read under ROM protection faulted");

    a_ap01_user: assert property (sect_client && sect_ap == AP_SUPER_RW && req_r.user
                                  |=> RSP.fault_code == FC_SECT_PERM)
        else $error("user access to supervisor section allowed");

    a_ap11_open: assert property (sect_client && sect_ap == AP_ALL_RW && !(sys_prot && rom_prot)
                                  |=> !RSP.fault)
        else $error("fully open section faulted");

    a_l2_invalid: assert property (st_l2 && FETCH_VALID && l2_type == L2_INVALID
                                   |=> RSP_VALID && RSP.fault_code == FC_PAGE_TRANS)
        else $error("invalid entry did not fault");

    a_page_cache: assert property (st_l2 && FETCH_VALID && !fin_fault && FETCH_DATA[DESC_C_BIT] && cache_en
                                   |=> RSP.cacheable)
        else $error("cacheable page not marked cacheable");

    a_sub_open: assert property (st_l2 && FETCH_VALID && !l2_bad && page_dmode == DOM_CLIENT
                                 && sub_ap == AP_ALL_RW && !(sys_prot && rom_prot) |=> !RSP.fault)
        else $error("open sub-page faulted");

    a_large_page_pa: assert property (RSP_VALID && !RSP.fault && $past(st_l2) && $past(l2_type) == L2_LARGE
                                      |-> RSP.paddr[15:0] == req_r.vaddr[15:0])
        else $error("large page offset wrong");

    // A fetch is never requested twice in a row, the answer needs a cycle
    a_fetch_pulse: assert property (FETCH_REQ |=> !FETCH_REQ)
        else $error("fetch request longer than one cycle");
endmodule

/* File: src/dpc_pkg.sv */
// Constants, field positions and carrier types for the descriptor permission checker.
// Assumes a 32-bit physical address space and a single core clock domain.
package dpc_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned REG_ADDR_W = 8;
    localparam logic [7:0] REG_TABLE_BASE = 8'h00;
    localparam logic [7:0] REG_DOMAIN_CTRL = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_LAST_PADDR = 8'h10;

    localparam logic [31:0] RST_TABLE_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_DOMAIN_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;

    // Control register bit positions
    localparam int unsigned CTRL_CACHE_EN = 2;
    localparam int unsigned CTRL_WBUF_EN = 3;
    localparam int unsigned CTRL_SYS_PROT = 8;
    localparam int unsigned CTRL_ROM_PROT = 9;

    // Status register bit positions
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_FAULT = 1;
    localparam int unsigned STAT_CODE_LSB = 4;
    localparam int unsigned STAT_DOM_LSB = 8;

    // Table base keeps bits 31:14, the table sits on a 16KB boundary
    localparam int unsigned TTB_LSB = 14;

    // ------------------------------------------------------------
    // Descriptor encodings
    // ------------------------------------------------------------
    localparam logic [1:0] L1_INVALID = 2'h0;
    localparam logic [1:0] L1_PAGE_TABLE = 2'h1;
    localparam logic [1:0] L1_SECTION = 2'h2;
    localparam logic [1:0] L1_RESERVED = 2'h3;
    localparam logic [1:0] L2_INVALID = 2'h0;
    localparam logic [1:0] L2_LARGE = 2'h1;
    localparam logic [1:0] L2_SMALL = 2'h2;
    localparam logic [1:0] L2_RESERVED = 2'h3;

    localparam int unsigned DESC_B_BIT = 2;
    localparam int unsigned DESC_C_BIT = 3;
    localparam int unsigned DESC_DOM_LSB = 5;
    localparam int unsigned SECT_AP_LSB = 10;
    localparam int unsigned PTE_AP_LSB = 4;

    // Domain modes
    localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_RESERVED = 2'h2;
    localparam logic [1:0] DOM_MANAGER = 2'h3;

    // Permission field values
    localparam logic [1:0] AP_SPECIAL = 2'h0;
    localparam logic [1:0] AP_SUPER_RW = 2'h1;
    localparam logic [1:0] AP_USER_RO = 2'h2;
    localparam logic [1:0] AP_ALL_RW = 2'h3;

    // Fault codes, zero means no fault
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_SECT_TRANS = 4'h5;
    localparam logic [3:0] FC_PAGE_TRANS = 4'h7;
    localparam logic [3:0] FC_SECT_DOMAIN = 4'h9;
    localparam logic [3:0] FC_PAGE_DOMAIN = 4'hB;
    localparam logic [3:0] FC_SECT_PERM = 4'hD;
    localparam logic [3:0] FC_PAGE_PERM = 4'hF;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_L1 = 3'h2,
        ST_L2 = 3'h4
    } dpc_state_t;

    typedef struct packed {
        logic [31:0] vaddr;
        logic write;
        logic user;
    } dpc_req_t;

    typedef struct packed {
        logic fault;
        logic [3:0] fault_code;
        logic [3:0] domain;
        logic [31:0] paddr;
        logic cacheable;
        logic bufferable;
    } dpc_rsp_t;

endpackage

/* File: verif/dpc_mem_model.sv */
// Behavioural translation table memory on the fetch port of the permission checker.
// Assumes one fetch at a time; the bench fills mem before each access.
`timescale 1ns/1ns
module dpc_mem_model (
    // Clock
    input wire logic CORE_CLK,
    // Fetch port
    input wire logic FETCH_REQ,
    input wire logic [31:0] FETCH_ADDR,
    output logic FETCH_VALID,
    output logic [31:0] FETCH_DATA,
    // Cycles of delay after the first possible answer cycle
    input wire logic [3:0] LATENCY
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] addr;

    initial begin
        FETCH_VALID = 1'b0;
        FETCH_DATA = 32'h0;
    end

    // Unwritten words read as invalid; data is scrambled outside the answer cycle
    always begin
        @(posedge CORE_CLK);
        if (FETCH_REQ === 1'b1) begin
            addr = FETCH_ADDR;
            repeat (LATENCY) @(posedge CORE_CLK);
            FETCH_VALID <= 1'b1;
            FETCH_DATA <= mem.exists(addr) ? mem[addr] : 32'h0;
            @(posedge CORE_CLK);
            FETCH_VALID <= 1'b0;
            FETCH_DATA <= ~FETCH_DATA;
        end
    end
endmodule

/* File: verif/dpc_descriptor_perm_check_tb.sv */
// Self-checking bench for the descriptor permission checker.
// Assumes the memory model answers every fetch; descriptors are planted per access.
`timescale 1ns/1ns
module dpc_descriptor_perm_check_tb;
    import dpc_pkg::*;
    logic core_clk, srst, reg_wr, reg_rd, req_valid, req_ready, rsp_valid, fetch_req, fetch_valid;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_data;
    logic [3:0] latency;
    dpc_req_t req;
    dpc_rsp_t rsp;
    int err_count, check_count;
    localparam logic [31:0] TTB = 32'h0000_4000;
    localparam logic [31:0] PTB = 32'h0000_8000;

    dpc_descriptor_perm_check dpc_descriptor_perm_check_i (.CORE_CLK(core_clk), .SRST(srst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
        .FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data));
    dpc_mem_model dpc_mem_model_i (.CORE_CLK(core_clk), .FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr),
        .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data), .LATENCY(latency));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rsp(input string name, input dpc_rsp_t exp, input dpc_rsp_t got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk_word(name, exp, reg_rdata);
    endtask

    // Sends one access and checks the whole answer plus the last fetch address
    task automatic run(input logic [31:0] va, input logic wr, input logic usr, input logic [3:0] code,
                       input logic [3:0] dom, input logic [31:0] pa, input logic ce, input logic [31:0] fa);
        int n;
        dpc_rsp_t e;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{vaddr: va, write: wr, user: usr};
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        e.fault = (code != FC_NONE);
        e.fault_code = code;
        e.domain = dom;
        e.paddr = e.fault ? 32'h0 : pa;
        e.cacheable = !e.fault && ce;
        e.bufferable = !e.fault && ce && wr;
        chk_word("answer valid", 32'h1, {31'h0, rsp_valid});
        chk_word("ready", 32'h1, {31'h0, req_ready});
        chk_rsp("answer", e, rsp);
        chk_word("fetch address", fa, fetch_addr);
    endtask

    function automatic logic perm_ok(input logic [1:0] ap, input logic s, input logic rp, input logic usr,
                                     input logic wr);
        if (s && rp) return 1'b0;
        case (ap)
            AP_SPECIAL: return s ? (!usr && !wr) : (rp && !wr);
            AP_SUPER_RW: return !usr;
            AP_USER_RO: return !usr || !wr;
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] l1a(input logic [31:0] va);
        return {TTB[31:14], va[31:20], 2'b00};
    endfunction

    task automatic test_regs();
        reg_check("table base reset", REG_TABLE_BASE, RST_TABLE_BASE);
        reg_check("control reset", REG_CONTROL, RST_CONTROL);
        reg_write(REG_TABLE_BASE, 32'hFFFF_FFFF);
        reg_check("table base", REG_TABLE_BASE, 32'hFFFF_C000);
        reg_write(REG_CONTROL, 32'hFFFF_FFFF);
        reg_check("control", REG_CONTROL, 32'h0000_030C);
        reg_check("unmapped", 8'h20, 32'h0);
        reg_write(REG_TABLE_BASE, TTB);
        // Domain 3 client, 5 no access, 6 reserved, 7 manager
        reg_write(REG_DOMAIN_CTRL, 32'h0000_E040);
    endtask

    task automatic test_section_perm();
        logic [31:0] va;
        logic [1:0] ap, sr, m;
        va = 32'h1230_0ABC;
        for (int k = 0; k < 64; k++) begin
            {ap, sr, m} = k[5:0];
            latency = k[0] ? 4'h2 : 4'h0;
            reg_write(REG_CONTROL, {22'h0, sr, 4'h0, ap[0], ap[0], 2'b00});
            // Bit 4 set as software should
            dpc_mem_model_i.mem[l1a(va)] = {12'hABC, 8'h00, ap, 1'b0, 4'h3, 3'b111, L1_SECTION};
            run(va, m[0], m[1], perm_ok(ap, sr[0], sr[1], m[1], m[0]) ? FC_NONE : FC_SECT_PERM, 4'h3,
                {12'hABC, va[19:0]}, ap[0], l1a(va));
        end
    endtask

    task automatic test_section_faults();
        logic [3:0] doms [4] = '{4'h5, 4'h6, 4'h7, 4'h3};
        logic [3:0] codes [4] = '{FC_SECT_DOMAIN, FC_SECT_DOMAIN, FC_NONE, FC_SECT_PERM};
        logic [31:0] va;
        va = 32'h4560_0010;
        reg_write(REG_CONTROL, 32'h0000_000C);
        for (int k = 0; k < 4; k++) begin
            dpc_mem_model_i.mem[l1a(va)] = {12'h456, 8'h00, 2'b00, 1'b0, doms[k], 3'b111, L1_SECTION};
            run(va, 1'b1, 1'b1, codes[k], doms[k], {12'h456, va[19:0]}, 1'b1, l1a(va));
        end
        reg_check("status", REG_STATUS, {20'h0, 4'h3, FC_SECT_PERM, 4'h2});
        for (int t = 0; t < 4; t += 3) begin
            dpc_mem_model_i.mem[l1a(va)] = {23'h0, 4'h9, 3'b000, 2'(t)};
            run(va, 1'b0, 1'b0, FC_SECT_TRANS, 4'h9, 32'h0, 1'b0, l1a(va));
        end
    endtask

    task automatic test_pages();
        logic [31:0] va, pte, pa, l2;
        logic [3:0] code;
        for (int k = 0; k < 22; k++) begin
            latency = k[1] ? 4'h1 : 4'h0;
            va = k[3] ? (32'h2340_0123 | (32'(k[2:1]) << 14)) : (32'h2340_5034 | (32'(k[2:1]) << 10));
            l2 = {PTB[31:10], va[19:12], 2'b00};
            // Large entries keep bits 15:12 zero as software must
            pte = k[3] ? {16'h9ABC, 4'h0, 8'hE4, 2'b11, L2_LARGE} : {20'h9ABCD, 8'hE4, 2'b11, L2_SMALL};
            pa = k[3] ? {16'h9ABC, va[15:0]} : {20'h9ABCD, va[11:0]};
            code = perm_ok(k[2:1], 1'b0, 1'b0, 1'b1, k[0]) ? FC_NONE : FC_PAGE_PERM;
            if (k >= 16) begin
                pte = {30'h0, 2'(k[0] ? 3 : 0)};
                code = FC_PAGE_TRANS;
            end
            if (k >= 20) begin
                pte = {20'h9ABCD, 8'hFF, 2'b11, L2_SMALL};
                code = FC_PAGE_DOMAIN;
            end
            dpc_mem_model_i.mem[l1a(va)] = {PTB[31:10], 1'b0, (k >= 20) ? 4'h5 : 4'h3, 3'b100, L1_PAGE_TABLE};
            dpc_mem_model_i.mem[l2] = pte;
            run(va, k[0], 1'b1, code, (k >= 20) ? 4'h5 : 4'h3, pa, 1'b1, l2);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        final_report();
    end

    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = 32'h0;
        req_valid = 1'b0;
        req = '0;
        latency = 4'h0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        test_regs();
        test_section_perm();
        test_section_faults();
        test_pages();
        final_report();
    end
endmodule
